// *** pdrc_core.sv ***
/*
  Playback dynamic range compressor, two channels. Holds the three
  compressor registers, watches each channel's output level once per
  accepted sample (one DAC word clock) and steers a per-channel cut in dB
  through attack, hold and decay. Samples leave through a two-entry
  buffer towards the volume stage.
  Assumes: register writes arrive as one-cycle strobes; one accepted
  sample is one word clock; the volume stage keeps left and right volume
  independent while compression runs.

  // Overview of operation
  // - Left enable bit 6, right bit 5
  // - Threshold code maps -3 to -24 dB
  // - Hysteresis code maps 0 to 3 dB
  // - Hold code zero means decay at once
  // - Hold counts 32 doubling, top codes 4x,5x32768
  // - Attack from 4 dB per word, halving
  // - Decay from 1.5625e-2 dB per word, halving
  // - Channel gains stay independent while compressing
*/
`timescale 1ns/1ns
module pdrc_core (
  input wire logic ref_clk, // 25 MHz system clock
  input wire logic rst, // Async reset, high
  input wire logic [6:0] reg_addr, // Register number
  input wire logic reg_wr, // Write strobe
  input wire logic [7:0] reg_wdata, // Write data
  input wire logic reg_rd, // Read strobe
  output logic [7:0] reg_rdata, // Read data, next cycle
  input wire logic in_valid, // Playback word offered
  output logic in_ready, // Compressor takes word
  input wire pdrc_pkg::pdrc_stereo_s in_data, // Playback word
  output logic out_valid, // Compressed word held
  input wire logic out_ready, // Volume stage takes
  output pdrc_pkg::pdrc_stereo_s out_data, // Compressed word
  output logic [1:0] comp_active // Cut in force, {left,right}
);

  // Configuration registers
  logic [7:0] ena_thr_reg, ena_thr_next; // Enables, threshold
  logic [7:0] hold_reg, hold_next; // Hold code
  logic [7:0] atk_dec_reg, atk_dec_next; // Rates
  logic [7:0] rdata_reg, rdata_next; // Read data

  // Per-channel gain state, index 1 left, 0 right
  pdrc_pkg::pdrc_state_e st_reg [2];
  pdrc_pkg::pdrc_state_e st_next [2];
  logic [31:0] att_reg [2]; // Cut in dB, Q8.24
  logic [31:0] att_next [2];
  logic [17:0] hcnt_reg [2]; // Hold words left
  logic [17:0] hcnt_next [2];

  // Decoded fields
  logic [1:0] chan_en; // {left, right}
  logic [2:0] thr_code;
  logic [1:0] hyst_code;
  logic [3:0] hold_code;
  logic [3:0] atk_code;
  logic [3:0] dec_code;
  logic [15:0] thr_mag; // Attack above this
  logic [15:0] rel_mag; // Decay below this
  logic [31:0] atk_step; // dB per word
  logic [31:0] dec_step; // dB per word
  logic [17:0] hold_len; // Words of hold

  // Stream signals
  logic step; // One word clock
  logic [15:0] smp [2]; // Raw sample per channel
  logic [15:0] cut [2]; // Compressed sample
  logic [15:0] mag [2]; // Output magnitude
  pdrc_pkg::pdrc_stereo_s comp_word; // Word to buffer

  // Attack step: halves per code, two top codes fixed
  function automatic logic [31:0] attack_rate(input logic [3:0] code);
    case (code)
      4'hE: attack_rate = pdrc_pkg::ATK_CODE14;
      4'hF: attack_rate = pdrc_pkg::ATK_CODE15;
      default: attack_rate = pdrc_pkg::ATK_BASE >> code;
    endcase
  endfunction

  // Hold length: doubling codes, two top codes fixed
  function automatic logic [17:0] hold_words(input logic [3:0] code);
    case (code)
      4'h0: hold_words = 18'h0_0000;
      4'hE: hold_words = pdrc_pkg::HOLD_X4;
      4'hF: hold_words = pdrc_pkg::HOLD_X5;
      default: hold_words = pdrc_pkg::HOLD_BASE << (code - 4'h1);
    endcase
  endfunction

  // Threshold as a full-scale magnitude, -3 dB to -24 dB
  // Each code is 3 dB lower than the last
  function automatic logic [15:0] thr_level(input logic [2:0] code);
    case (code)
      3'h0: thr_level = 16'h5A9E;
      3'h1: thr_level = 16'h4027;
      3'h2: thr_level = 16'h2D6B;
      3'h3: thr_level = 16'h2027;
      3'h4: thr_level = 16'h16C3;
      3'h5: thr_level = 16'h101D;
      3'h6: thr_level = 16'h0B68;
      default: thr_level = 16'h0813;
    endcase
  endfunction

  // Magnitude; the most negative word gives 16'h8000, not clipped
  function automatic logic [15:0] magnitude(input logic [15:0] s);
    logic [16:0] wide;
    wide = s[15] ? (17'h0_0000 - {s[15], s}) : {1'b0, s};
    magnitude = wide[16] ? 16'hFFFF : wide[15:0];
  endfunction

  // Field decode
  always_comb begin
    chan_en = {ena_thr_reg[pdrc_pkg::LEFT_EN_BIT],
               ena_thr_reg[pdrc_pkg::RIGHT_EN_BIT]};
    thr_code = ena_thr_reg[pdrc_pkg::THR_LSB +: 3];
    hyst_code = ena_thr_reg[pdrc_pkg::HYST_LSB +: 2];
    hold_code = hold_reg[pdrc_pkg::HOLD_LSB +: 4];
    atk_code = atk_dec_reg[pdrc_pkg::ATK_LSB +: 4];
    dec_code = atk_dec_reg[pdrc_pkg::DEC_LSB +: 4];
  end

  // Levels and rates from the codes
  always_comb begin
    logic [24:0] rel_prod;
    rel_prod = '0;
    thr_mag = thr_level(thr_code);
    // Release level sits the hysteresis below the threshold
    rel_prod = thr_mag * pdrc_pkg::db_factor({1'b0, hyst_code});
    rel_mag = rel_prod[23:8];
    atk_step = attack_rate(atk_code);
    dec_step = pdrc_pkg::DEC_BASE >> dec_code;
    // Hold counts words, following the rate
    hold_len = hold_words(hold_code);
  end

  // Register write and read, next values
  always_comb begin
    ena_thr_next = ena_thr_reg;
    hold_next = hold_reg;
    atk_dec_next = atk_dec_reg;
    rdata_next = rdata_reg;
    if (reg_wr) begin
      // Reserved bits are masked, so a stray write cannot flip them
      case (reg_addr)
        pdrc_pkg::REG_ENA_THR: begin
          ena_thr_next = (reg_wdata & pdrc_pkg::WMASK_ENA_THR) |
                         (pdrc_pkg::RST_ENA_THR & ~pdrc_pkg::WMASK_ENA_THR);
        end
        pdrc_pkg::REG_HOLD: begin
          hold_next = (reg_wdata & pdrc_pkg::WMASK_HOLD) |
                      (pdrc_pkg::RST_HOLD & ~pdrc_pkg::WMASK_HOLD);
        end
        pdrc_pkg::REG_ATK_DEC: begin
          atk_dec_next = reg_wdata & pdrc_pkg::WMASK_ATK_DEC;
        end
        default: begin
          // Other registers belong to other blocks
        end
      endcase
    end
    // Read with write returns the old value
    if (reg_rd) begin
      case (reg_addr)
        pdrc_pkg::REG_ENA_THR: rdata_next = ena_thr_reg;
        pdrc_pkg::REG_HOLD: rdata_next = hold_reg;
        pdrc_pkg::REG_ATK_DEC: rdata_next = atk_dec_reg;
        default: rdata_next = 8'h00;
      endcase
    end
  end

  // Register bank storage
  // Reset restores power-on defaults
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      ena_thr_reg <= pdrc_pkg::RST_ENA_THR;
      hold_reg <= pdrc_pkg::RST_HOLD;
      atk_dec_reg <= pdrc_pkg::RST_ATK_DEC;
      rdata_reg <= 8'h00;
    end else begin
      ena_thr_reg <= ena_thr_next;
      hold_reg <= hold_next;
      atk_dec_reg <= atk_dec_next;
      rdata_reg <= rdata_next;
    end
  end

  assign reg_rdata = rdata_reg;

  // A word taken from upstream is one word clock
  // A stall also pauses hold and decay
  assign step = in_valid && in_ready;
  assign smp[1] = in_data.left;
  assign smp[0] = in_data.right;

  // Each channel gets its own cut, never shared
  for (genvar c = 0; c < 2; c++) begin : g_chan
    pdrc_gain_apply u_apply (
      .sample(smp[c]),
      .cut_db(att_reg[c][31:pdrc_pkg::ATT_FRAC]),
      .result(cut[c])
    );
    // Level judged after the cut
    assign mag[c] = magnitude(cut[c]);
  end

  // Compressed word, or the raw word where a channel is bypassed
  always_comb begin
    comp_word.left = chan_en[1] ? cut[1] : smp[1];
    comp_word.right = chan_en[0] ? cut[0] : smp[0];
  end

  // Gain state machines, next values for both channels
  always_comb begin
    for (int c = 0; c < 2; c++) begin
      st_next[c] = st_reg[c];
      att_next[c] = att_reg[c];
      hcnt_next[c] = hcnt_reg[c];
      if (!chan_en[c]) begin
        // Bypass drops any cut so re-enabling starts clean
        st_next[c] = pdrc_pkg::ST_IDLE;
        att_next[c] = 32'h0000_0000;
        hcnt_next[c] = 18'h0_0000;
      end else if (step) begin
        case (st_reg[c])
          pdrc_pkg::ST_IDLE, pdrc_pkg::ST_ATTACK, pdrc_pkg::ST_HOLD,
          pdrc_pkg::ST_DECAY: begin
            if (mag[c] > thr_mag) begin
              // Over threshold: cut harder, rearm hold
              st_next[c] = pdrc_pkg::ST_ATTACK;
              hcnt_next[c] = hold_len;
              // Clamp so the sum cannot wrap
              if (att_reg[c] >= pdrc_pkg::ATT_MAX - atk_step) begin
                att_next[c] = pdrc_pkg::ATT_MAX;
              end else begin
                att_next[c] = att_reg[c] + atk_step;
              end
            end else if (mag[c] < rel_mag && att_reg[c] != '0) begin
              if (hcnt_reg[c] != 18'h0_0000) begin
                // Still holding the cut
                st_next[c] = pdrc_pkg::ST_HOLD;
                hcnt_next[c] = hcnt_reg[c] - 18'h0_0001;
              end else begin
                // Hold done or disabled: recover gain
                st_next[c] = pdrc_pkg::ST_DECAY;
                // Floor at zero, no wrap
                if (att_reg[c] <= dec_step) begin
                  att_next[c] = 32'h0000_0000;
                end else begin
                  att_next[c] = att_reg[c] - dec_step;
                end
              end
            end else if (att_reg[c] == '0) begin
              st_next[c] = pdrc_pkg::ST_IDLE;
            end else begin
              // Inside the hysteresis band the cut stands
              st_next[c] = pdrc_pkg::ST_HOLD;
            end
          end
          default: begin
            // Unused with four states
            st_next[c] = pdrc_pkg::ST_IDLE;
          end
        endcase
      end
    end
  end

  // Gain state storage
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      for (int c = 0; c < 2; c++) begin
        st_reg[c] <= pdrc_pkg::ST_IDLE;
        att_reg[c] <= 32'h0000_0000;
        hcnt_reg[c] <= 18'h0_0000;
      end
    end else begin
      st_reg <= st_next;
      att_reg <= att_next;
      hcnt_reg <= hcnt_next;
    end
  end

  // Status shows which channel currently carries a cut
  assign comp_active = {att_reg[1] != '0, att_reg[0] != '0};

  // Output buffer; its ready stalls upstream so no word is lost
  pdrc_skid u_skid (
    .ref_clk(ref_clk),
    .rst(rst),
    .in_valid(in_valid),
    .in_ready(in_ready),
    .in_data(comp_word),
    .out_valid(out_valid),
    .out_ready(out_ready),
    .out_data(out_data)
  );

endmodule

// *** pdrc_core_sva.sv ***
/*
  Checker for the compressor core: buffer flags, output holding,
  register read-back against shadow copies, and gain state links.
  Assumes it sees only the core's ports; bound below the module.
*/
`timescale 1ns/1ns
module pdrc_core_sva (
  input wire logic ref_clk, // Clock
  input wire logic rst, // Reset, high
  input wire logic [6:0] reg_addr, // Register number
  input wire logic reg_wr, // Write strobe
  input wire logic [7:0] reg_wdata, // Write data
  input wire logic reg_rd, // Read strobe
  input wire logic [7:0] reg_rdata, // Read data
  input wire logic in_valid, // Word offered
  input wire logic in_ready, // Core takes
  input wire pdrc_pkg::pdrc_stereo_s in_data, // Word in
  input wire logic out_valid, // Word held
  input wire logic out_ready, // Receiver takes
  input wire pdrc_pkg::pdrc_stereo_s out_data, // Word out
  input wire logic [1:0] comp_active // Cut in force
);
  default clocking dcb @(posedge ref_clk);
  endclocking
  default disable iff (rst);

  logic [1:0] cnt; // Words in the buffer
  logic [7:0] sh_et; // Shadow of enables and threshold
  logic [7:0] sh_ht; // Shadow of hold time
  logic [7:0] sh_ad; // Shadow of attack and decay
  wire take_in = in_valid && in_ready; // Word accepted
  wire take_out = out_valid && out_ready; // Word delivered

  // Masked write; reserved bits never change
  function automatic logic [7:0] upd(input logic [7:0] old,
    input logic [6:0] a, input logic [7:0] m);
    upd = (reg_wr && reg_addr == a) ? ((old & ~m) | (reg_wdata & m)) : old;
  endfunction

  // Shadow registers and buffer fill
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      cnt <= 2'h0;
      sh_et <= pdrc_pkg::RST_ENA_THR;
      sh_ht <= pdrc_pkg::RST_HOLD;
      sh_ad <= pdrc_pkg::RST_ATK_DEC;
    end else begin
      cnt <= cnt + 2'(take_in) - 2'(take_out);
      sh_et <= upd(sh_et, pdrc_pkg::REG_ENA_THR, pdrc_pkg::WMASK_ENA_THR);
      sh_ht <= upd(sh_ht, pdrc_pkg::REG_HOLD, pdrc_pkg::WMASK_HOLD);
      sh_ad <= upd(sh_ad, pdrc_pkg::REG_ATK_DEC, pdrc_pkg::WMASK_ATK_DEC);
    end
  end

  property p_buf_flags;
    in_ready == (cnt != 2'h2) && out_valid == (cnt != 2'h0);
  endproperty
  a_buf_flags: assert property (p_buf_flags)
    else $error("Buffer flags disagree with fill");
  property p_out_stand;
    out_valid && !out_ready |=> out_valid && $stable(out_data);
  endproperty
  a_out_stand: assert property (p_out_stand)
    else $error("Held word changed during stall");
  property p_out_rise;
    take_in && cnt == 2'h0 |=> out_valid;
  endproperty
  a_out_rise: assert property (p_out_rise)
    else $error("Word not offered one cycle after taking");
  property p_rd_unmapped;
    reg_rd && !(reg_addr inside {[7'h44:7'h46]}) |=> reg_rdata == 8'h00;
  endproperty
  a_rd_unmapped: assert property (p_rd_unmapped)
    else $error("Unmapped read not zero");
  property p_rd_stand;
    !reg_rd |=> $stable(reg_rdata);
  endproperty
  a_rd_stand: assert property (p_rd_stand)
    else $error("Read data changed without a read");
  property p_rd_et;
    reg_rd && reg_addr == pdrc_pkg::REG_ENA_THR |=> reg_rdata == $past(sh_et);
  endproperty
  a_rd_et: assert property (p_rd_et)
    else $error("Enable and threshold read-back wrong");
  property p_rd_ht;
    reg_rd && reg_addr == pdrc_pkg::REG_HOLD |=> reg_rdata == $past(sh_ht);
  endproperty
  a_rd_ht: assert property (p_rd_ht)
    else $error("Hold read-back wrong");
  property p_rd_ad;
    reg_rd && reg_addr == pdrc_pkg::REG_ATK_DEC |=> reg_rdata == $past(sh_ad);
  endproperty
  a_rd_ad: assert property (p_rd_ad)
    else $error("Rate read-back wrong");
  property p_dis_left;
    !sh_et[6] [*2] |-> !comp_active[1];
  endproperty
  a_dis_left: assert property (p_dis_left)
    else $error("Left cut while left disabled");
  property p_dis_right;
    !sh_et[5] [*2] |-> !comp_active[0];
  endproperty
  a_dis_right: assert property (p_dis_right)
    else $error("Right cut while right disabled");
  property p_rise_word;
    $rose(comp_active[1]) |-> $past(take_in);
  endproperty
  a_rise_word: assert property (p_rise_word)
    else $error("Cut began without a taken word");

  c_stall: cover property (out_valid && !out_ready && !in_ready);
  c_release: cover property ($fell(comp_active[1]));
  c_unmapped: cover property (reg_rd && reg_addr == 7'h47);
endmodule

bind pdrc_core pdrc_core_sva i_pdrc_core_sva (.ref_clk, .rst, .reg_addr,
  .reg_wr, .reg_wdata, .reg_rd, .reg_rdata, .in_valid, .in_ready, .in_data,
  .out_valid, .out_ready, .out_data, .comp_active);

// *** pdrc_gain_apply.sv ***
/*
  Applies a cut given in whole dB to one sample: 6 dB per halving plus a
  Q8 factor for the remaining 0 to 5 dB. Purely combinational.
  Assumes the cut never exceeds the compressor ceiling of 48 dB.
*/
`timescale 1ns/1ns
module pdrc_gain_apply (
  input wire logic [15:0] sample, // Signed sample in
  input wire logic [7:0] cut_db, // Whole dB of cut
  output logic [15:0] result // Signed sample out
);

  logic [7:0] shift; // Whole halvings
  logic [2:0] rest; // Leftover dB
  logic signed [25:0] prod; // Sample times factor

  // Split the cut, scale, then shift with sign
  always_comb begin
    shift = cut_db / 8'h6;
    rest = 3'(cut_db - shift * 8'h6);
    prod = $signed(sample) * $signed({1'b0, pdrc_pkg::db_factor(rest)});
    prod = prod >>> 8;
    if (shift > 8'h0F) begin
      // Beyond 95 dB the word is silent anyway
      result = 16'h0000;
    end else begin
      prod = prod >>> shift;
      result = prod[15:0];
    end
  end

endmodule

// *** pdrc_pkg.sv ***
/*
  Shared definitions for the playback dynamic range compressor: register
  offsets, field positions, reset values, rate and level tables, the
  stereo sample carrier and the per-channel state encoding.
  Assumes an 8-bit register port with a 7-bit register number and 16-bit
  two's complement playback samples.
*/
package pdrc_pkg;

  // Register numbers
  localparam logic [6:0] REG_ENA_THR = 7'h44; // Enables, threshold, hysteresis
  localparam logic [6:0] REG_HOLD = 7'h45; // Hold time
  localparam logic [6:0] REG_ATK_DEC = 7'h46; // Attack and decay rates

  // Reset values
  localparam logic [7:0] RST_ENA_THR = 8'h0F; // Off, -12 dB, 3 dB
  localparam logic [7:0] RST_HOLD = 8'h38; // Hold code 0111
  localparam logic [7:0] RST_ATK_DEC = 8'h00; // Fastest rates

  // Writable bits; reserved bits keep their reset value
  localparam logic [7:0] WMASK_ENA_THR = 8'h7F;
  localparam logic [7:0] WMASK_HOLD = 8'h78;
  localparam logic [7:0] WMASK_ATK_DEC = 8'hFF;

  // Field positions
  localparam int LEFT_EN_BIT = 6;
  localparam int RIGHT_EN_BIT = 5;
  localparam int THR_LSB = 2;
  localparam int HYST_LSB = 0;
  localparam int HOLD_LSB = 3;
  localparam int ATK_LSB = 4;
  localparam int DEC_LSB = 0;

  // Attenuation in dB, 8 integer and 24 fraction bits
  localparam int ATT_FRAC = 24;
  localparam logic [31:0] ATT_MAX = 32'h3000_0000; // 48 dB ceiling
  localparam logic [31:0] ATK_BASE = 32'h0400_0000; // 4 dB per word
  localparam logic [31:0] ATK_CODE14 = 32'h0000_019A; // 2.4414e-5 dB
  localparam logic [31:0] ATK_CODE15 = 32'h0000_00CD; // 1.2207e-5 dB
  localparam logic [31:0] DEC_BASE = 32'h0004_0000; // 1.5625e-2 dB

  // Hold counts in word clocks
  localparam logic [17:0] HOLD_BASE = 18'h0_0020; // 32 words
  localparam logic [17:0] HOLD_X4 = 18'h2_0000; // 4 * 32768
  localparam logic [17:0] HOLD_X5 = 18'h2_8000; // 5 * 32768

  // Stereo sample carrier
  typedef struct packed {
    logic [15:0] left;
    logic [15:0] right;
  } pdrc_stereo_s;

  // Per-channel gain state
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_ATTACK = 2'b01,
    ST_HOLD = 2'b10,
    ST_DECAY = 2'b11
  } pdrc_state_e;

  // Linear factor in Q8 for 0 to 5 dB of cut
  function automatic logic [8:0] db_factor(input logic [2:0] db);
    case (db)
      3'h0: db_factor = 9'h100;
      3'h1: db_factor = 9'h0E4;
      3'h2: db_factor = 9'h0CB;
      3'h3: db_factor = 9'h0B5;
      3'h4: db_factor = 9'h0A1;
      default: db_factor = 9'h090;
    endcase
  endfunction

endpackage

// *** pdrc_skid.sv ***
/*
  Two-entry buffer between the compressor and the volume stage.
  Assumes a receiver that may stall at any time; full and empty are exact.
*/
`timescale 1ns/1ns
module pdrc_skid (
  input wire logic ref_clk, // System clock
  input wire logic rst, // Async reset, high
  input wire logic in_valid, // Word offered
  output logic in_ready, // Room for a word
  input wire pdrc_pkg::pdrc_stereo_s in_data, // Word in
  output logic out_valid, // Word held
  input wire logic out_ready, // Receiver takes
  output pdrc_pkg::pdrc_stereo_s out_data // Word out, from flops
);

  pdrc_pkg::pdrc_stereo_s mem_reg [2]; // Two slots
  pdrc_pkg::pdrc_stereo_s mem_next [2];
  logic [1:0] cnt_reg, cnt_next; // Words held
  logic wp_reg, wp_next; // Write slot
  logic rp_reg, rp_next; // Read slot
  logic push, pop;

  // Handshakes come straight from the count
  assign in_ready = (cnt_reg != 2'h2);
  assign out_valid = (cnt_reg != 2'h0);
  assign out_data = mem_reg[rp_reg];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  // Next pointers, count and slot contents
  always_comb begin
    mem_next = mem_reg;
    wp_next = wp_reg;
    rp_next = rp_reg;
    cnt_next = cnt_reg;
    if (push) begin
      mem_next[wp_reg] = in_data;
      wp_next = ~wp_reg;
    end
    if (pop) begin
      rp_next = ~rp_reg;
    end
    // Push and pop together leave the count alone
    if (push && !pop) begin
      cnt_next = cnt_reg + 2'h1;
    end else if (pop && !push) begin
      cnt_next = cnt_reg - 2'h1;
    end
  end

  // Register stage
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      mem_reg[0] <= '0;
      mem_reg[1] <= '0;
      cnt_reg <= 2'h0;
      wp_reg <= 1'b0;
      rp_reg <= 1'b0;
    end else begin
      mem_reg <= mem_next;
      cnt_reg <= cnt_next;
      wp_reg <= wp_next;
      rp_reg <= rp_next;
    end
  end

endmodule

// *** pdrc_vol_sink.sv ***
/*
  Volume-stage model at the far side of the compressor stream: takes
  words unless the bench asks it to stall, and reports each word taken.
  Assumes the core's valid/ready port and the single system clock.
*/
`timescale 1ns/1ns
module pdrc_vol_sink (
  input wire logic ref_clk, // System clock
  input wire logic rst, // Async reset, high
  input wire logic stall, // Bench back-pressure request
  input wire logic out_valid, // Word held by core
  output logic out_ready, // Taking words
  input wire pdrc_pkg::pdrc_stereo_s out_data, // Word from core
  output logic got_valid, // One-cycle pulse per word
  output pdrc_pkg::pdrc_stereo_s got_data // Last word taken
);
  // Ready follows stall only, so a stall can start on any cycle
  assign out_ready = !stall;

  // Capture each word; left and right kept apart, no volume coupling
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      got_valid <= 1'b0;
      got_data <= '0;
    end else begin
      got_valid <= out_valid && out_ready;
      if (out_valid && out_ready) begin
        got_data <= out_data;
      end
    end
  end
endmodule

// *** test_playback_dynamic_range_compressor.sv ***
/*
  Self-checking bench for the compressor core: registers, bypass and
  buffer refusal, threshold, hysteresis, attack and hold/decay counts.
  Assumes the volume-stage model and the bound checker.
*/
`timescale 1ns/1ns
module test_playback_dynamic_range_compressor;
  logic ref_clk = 1'b0; // 25 MHz clock
  logic rst = 1'b1; // Reset, high
  logic [6:0] reg_addr = 7'h00; // Register number
  logic reg_wr = 1'b0; // Write strobe
  logic [7:0] reg_wdata = 8'h00; // Write data
  logic reg_rd = 1'b0; // Read strobe
  logic [7:0] reg_rdata; // Read data
  logic in_valid = 1'b0; // Word offered
  logic in_ready; // Core takes
  pdrc_pkg::pdrc_stereo_s in_data = '0; // Word in
  logic out_valid; // Word held
  logic out_ready; // Sink takes
  pdrc_pkg::pdrc_stereo_s out_data; // Word out
  logic [1:0] comp_active; // Cut in force
  logic stall = 1'b0; // Sink back-pressure
  logic got_valid; // Sink took a word
  pdrc_pkg::pdrc_stereo_s got_data; // Word the sink took
  int err_total = 0; // Mismatches
  int tests_run = 0; // Comparisons
  int cycles = 0; // Run length guard
  // Threshold magnitudes, codes 0 to 7
  logic [15:0] thr_tab [8] = '{16'h5A9E, 16'h4027, 16'h2D6B, 16'h2027,
    16'h16C3, 16'h101D, 16'h0B68, 16'h0813};
  // Full-scale word after 4, 2 and 1 dB of cut
  logic [15:0] atk_tab [3] = '{16'h507F, 16'h657F, 16'h71FF};

  pdrc_core i_pdrc_core (.ref_clk, .rst, .reg_addr, .reg_wr, .reg_wdata,
    .reg_rd, .reg_rdata, .in_valid, .in_ready, .in_data, .out_valid,
    .out_ready, .out_data, .comp_active);
  pdrc_vol_sink i_pdrc_vol_sink (.ref_clk, .rst, .stall, .out_valid,
    .out_ready, .out_data, .got_valid, .got_data);

  // Clock, 40 ns period
  always #20 ref_clk = ~ref_clk;

  // Hang guard; the whole run needs well under a third of this
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 20000) begin
      err_total++;
      tally_and_finish();
    end
  end

  task automatic tally_and_finish;
    $display("Comparisons %0d mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
    tests_run++;
    if (got !== exp) begin
      err_total++;
      $display("BAD t=%0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic chk32(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      err_total++;
      $display("BAD t=%0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic chk2(input logic [1:0] got, input logic [1:0] exp);
    tests_run++;
    if (got !== exp) begin
      err_total++;
      $display("BAD t=%0t got %h exp %h", $time, got, exp);
    end
  endtask

  // One-cycle write strobe
  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    @(negedge ref_clk);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(negedge ref_clk);
    reg_wr = 1'b0;
  endtask

  // Read strobe; data is settled the cycle after
  task automatic rd(input logic [6:0] a, output logic [7:0] d);
    @(negedge ref_clk);
    reg_addr = a;
    reg_rd = 1'b1;
    @(negedge ref_clk);
    reg_rd = 1'b0;
    d = reg_rdata;
  endtask

  // Offer a word and hold it until the core can take it
  task automatic push(input logic [15:0] l, input logic [15:0] r);
    @(negedge ref_clk);
    in_valid = 1'b1;
    in_data = {l, r};
    while (in_ready !== 1'b1) begin
      @(negedge ref_clk);
    end
    @(negedge ref_clk);
    in_valid = 1'b0;
  endtask

  // Wait for the sink to take a word, compare if asked
  task automatic pull(input logic c, input logic [31:0] e);
    do begin
      @(negedge ref_clk);
    end while (got_valid !== 1'b1);
    if (c) begin
      chk32(got_data, e);
    end
  endtask

  task automatic send(input logic [15:0] l, input logic [15:0] el);
    push(l, 16'h7FFF);
    pull(1'b1, {el, 16'h7FFF});
  endtask

  // Disable first so any cut left over is cleared
  task automatic prime(input logic [7:0] et, input logic [7:0] ht,
    input logic [7:0] ad);
    wr(7'h44, 8'h00);
    wr(7'h45, ht);
    wr(7'h46, ad);
    wr(7'h44, et);
  endtask

  // Reset values, writable bits, unmapped place
  task automatic t_regs;
    logic [7:0] d;
    rd(7'h44, d);
    chk8(d, 8'h0F);
    rd(7'h45, d);
    chk8(d, 8'h38);
    rd(7'h46, d);
    chk8(d, 8'h00);
    wr(7'h44, 8'h7F);
    rd(7'h44, d);
    chk8(d, 8'h7F);
    wr(7'h45, 8'h78);
    rd(7'h45, d);
    chk8(d, 8'h78);
    wr(7'h47, 8'h5A);
    rd(7'h47, d);
    chk8(d, 8'h00);
    wr(7'h44, 8'h0F);
  endtask

  // Bypass words fill the buffer while the sink stalls
  task automatic t_fill;
    stall = 1'b1;
    push(16'h1234, 16'h8001);
    push(16'h7FFF, 16'h0042);
    @(negedge ref_clk);
    chk2({in_ready, out_valid}, 2'b01);
    stall = 1'b0;
    pull(1'b1, 32'h1234_8001);
    pull(1'b1, 32'h7FFF_0042);
  endtask

  // Level equal to threshold holds, one above attacks, both channels
  task automatic t_thr;
    for (int t = 0; t < 8; t++) begin
      prime({3'b011, 3'(t), 2'b11}, 8'h00, 8'h00);
      push(thr_tab[t], thr_tab[t]);
      pull(1'b1, {thr_tab[t], thr_tab[t]});
      chk2(comp_active, 2'b00);
      push(thr_tab[t] + 16'h0001, thr_tab[t] + 16'h0001);
      pull(1'b0, 32'h0000_0000);
      chk2(comp_active, 2'b11);
    end
  endtask

  // Level under threshold: stand or decay by hysteresis
  task automatic t_hyst;
    for (int h = 0; h < 4; h++) begin
      prime(8'h40 | 8'(h), 8'h00, 8'h00);
      send(16'h7FFF, 16'h7FFF);
      send(16'h7FFF, 16'h507F);
      send(16'h7FFF, (h > 1) ? 16'h507F : 16'h5A7F);
    end
  endtask

  // Attack codes 0 to 2 give 4, 2 and 1 dB on the first step
  task automatic t_atk;
    for (int c = 0; c < 3; c++) begin
      prime(8'h43, 8'h00, {4'(c), 4'h0});
      send(16'h7FFF, 16'h7FFF);
      send(16'h7FFF, atk_tab[c]);
    end
  endtask

  // One attack step, then count quiet words until the cut is gone
  task automatic t_count(input logic [3:0] hc, input logic [3:0] ac,
    input logic [3:0] dc, input int n);
    prime(8'h40, {1'b0, hc, 3'b000}, {ac, dc});
    push(16'h7FFF, 16'h0000);
    pull(1'b1, 32'h7FFF_0000);
    chk2(comp_active, 2'b10);
    repeat (n - 1) begin
      push(16'h0100, 16'h0000);
      pull(1'b0, 32'h0000_0000);
    end
    chk2(comp_active, 2'b10);
    push(16'h0100, 16'h0000);
    pull(1'b0, 32'h0000_0000);
    chk2(comp_active, 2'b00);
  endtask

  initial begin
    repeat (5) @(negedge ref_clk);
    rst = 1'b0;
    t_regs();
    t_fill();
    t_thr();
    t_hyst();
    t_atk();
    t_count(4'h0, 4'h0, 4'h0, 256);
    t_count(4'h1, 4'h0, 4'h0, 288);
    t_count(4'h2, 4'h2, 4'h0, 128);
    t_count(4'h0, 4'h2, 4'h1, 128);
    tally_and_finish();
  end
endmodule
